//--- core/doac_top.v
`timescale 1ns/1ps
`include "doac_regs.vh"

//////////////////////////////////////////////////////////////////////////////
// Operation
// (RULE1) Bit 7 picks general-purpose level or vertical blank when shared mux enabled.
// (RULE2) Bit 6 is the general-purpose level, seen only if bit 7 low, bit 5 high.
// (RULE3) Bit 5 enables the shared pin driver; resets to disabled.
// (RULE4) Bit 4 swaps PAL indicator and field id for lock indicators.
// (RULE5) Bit 3 low floats the pixel bus; high drives it; default low.
// (RULE6) Pixel bus driven only when bit 3 and the data-processor enable are high.
// (RULE7) Data-processor enable resets high, bit 3 low, so bus floats after reset.
// (RULE8) Bit 2 drives the four sync pins; low floats them; default low.
// (RULE9) Genlock on the field pin keeps it driven regardless of bit 2.
// (RULE10) Bit 1 turns vertical blanking off or on; default off.
// (RULE11) Bit 0 drives the pixel clock pin; resets to one.
// (RULE12) Software keeps bit 0 set when writing to enable outputs.
// (RULE13) Autoswitch mask bits 5..2 exclude SECAM, NTSC 4.43, PAL-N, PAL-M; reset DCh.
// (RULE14) Kill mode: 00 auto, 01 reserved, 10 forced kill, 11 killer off.
// (RULE15) Five-bit kill threshold, -18 dB at 00000 to -30 dB, reset 10000.
// (RULE16) Reserved bits read zero and ignore writes; fields reset to defaults. Reset DCh sets reserved bits 7:6 of the autoswitch mask to one.
module doac_top (
  input wire ref_clk,
  input wire rst_n,
  input wire scl_in,
  input wire sda_in,
  output wire sda_out,
  output reg sda_oe,
  input wire shared_pin_mux_enable,
  input wire pal_field_pins_selected,
  input wire genlock_selected,
  input wire data_processor_out_enable,
  input wire [7:0] pixel_data,
  input wire hsync_level,
  input wire vsync_level,
  input wire pal_indicator,
  input wire active_video_flag,
  input wire field_identifier,
  input wire genlock_output,
  input wire horizontal_lock_indicator,
  input wire vertical_lock_indicator,
  input wire vertical_blank_signal,
  input wire interrupt_request,
  output wire [7:0] pixel_output_bus,
  output wire pixel_output_bus_oe,
  output wire hsync_pin,
  output wire hsync_pin_oe,
  output wire vertical_sync_or_pal_indicator_pin,
  output wire vertical_sync_or_pal_indicator_pin_oe,
  output wire active_video_pin,
  output wire active_video_pin_oe,
  output wire field_or_genlock_pin,
  output wire field_or_genlock_pin_oe,
  output wire interrupt_request_pin,
  output wire interrupt_request_pin_oe,
  output wire pixel_clock_pin_oe,
  output wire vertical_blank_enable,
  output wire secam_autoswitch_mask,
  output wire ntsc443_autoswitch_mask,
  output wire paln_autoswitch_mask,
  output wire palm_autoswitch_mask,
  output wire chroma_kill_auto,
  output wire chroma_kill_force,
  output wire chroma_kill_disable,
  output wire [4:0] chroma_kill_threshold
);

  //////////////////////////////////////////////////////////////////////////////
  // Serial slave states
  localparam [8:0] ST_IDLE = 9'h001;
  localparam [8:0] ST_ADDR = 9'h002;
  localparam [8:0] ST_AACK = 9'h004;
  localparam [8:0] ST_SUB = 9'h008;
  localparam [8:0] ST_SACK = 9'h010;
  localparam [8:0] ST_WR = 9'h020;
  localparam [8:0] ST_WACK = 9'h040;
  localparam [8:0] ST_RD = 9'h080;
  localparam [8:0] ST_RACK = 9'h100;

  reg [8:0] state;
  reg scl_q;
  reg sda_q;
  reg [7:0] shreg;
  reg [7:0] txreg;
  reg [3:0] bitcnt;
  reg [7:0] subaddr;
  reg rw_read;
  reg wr_en;
  reg [7:0] rdata;

  wire [7:0] output_pin_control;
  wire [7:0] standard_autoswitch_mask;
  wire [7:0] chroma_kill_reg;

  wire scl_rise = scl_in & ~scl_q;
  wire scl_fall = ~scl_in & scl_q;
  wire bus_start = scl_in & scl_q & sda_q & ~sda_in;
  wire bus_stop = scl_in & scl_q & ~sda_q & sda_in;
  wire byte_done = (bitcnt == 4'h8);

  // Open-drain data line only ever pulls low
  assign sda_out = 1'b0;

  //////////////////////////////////////////////////////////////////////////////
  // Read mux; unmapped subaddresses read zero
  always @*
  begin
    case (subaddr)
      `DOAC_OFS_OUTPUT_PIN_CONTROL: rdata = output_pin_control;
      `DOAC_OFS_STANDARD_AUTOSWITCH_MASK: rdata = standard_autoswitch_mask;
      `DOAC_OFS_CHROMA_KILL_THRESHOLD: rdata = chroma_kill_reg;
      default: rdata = 8'h00;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Serial engine: sample on rising clock, change data line on falling clock
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= ST_IDLE;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      shreg <= 8'h00;
      txreg <= 8'h00;
      bitcnt <= 4'h0;
      subaddr <= 8'h00;
      rw_read <= 1'b0;
      wr_en <= 1'b0;
      sda_oe <= 1'b0;
    end
    else
    begin
      scl_q <= scl_in;
      sda_q <= sda_in;
      wr_en <= 1'b0;
      if (scl_rise)
      begin
        shreg <= {shreg[6:0], sda_in};
        bitcnt <= bitcnt + 4'h1;
      end
      if (bus_start)
      begin
        state <= ST_ADDR;
        bitcnt <= 4'h0;
        sda_oe <= 1'b0;
      end
      else if (bus_stop)
      begin
        state <= ST_IDLE;
        sda_oe <= 1'b0;
      end
      else if (scl_fall)
      begin
        case (state)
          ST_IDLE:
          begin
            sda_oe <= 1'b0;
          end
          ST_ADDR:
          begin
            if (byte_done)
            begin
              if (shreg[7:1] == `DOAC_SLAVE_ADDR)
              begin
                state <= ST_AACK;
                rw_read <= shreg[0];
                sda_oe <= 1'b1;
              end
              else
                state <= ST_IDLE;
            end
          end
          ST_AACK:
          begin
            bitcnt <= 4'h0;
            if (rw_read)
            begin
              state <= ST_RD;
              txreg <= rdata;
              sda_oe <= ~rdata[7];
            end
            else
            begin
              state <= ST_SUB;
              sda_oe <= 1'b0;
            end
          end
          ST_SUB:
          begin
            if (byte_done)
            begin
              subaddr <= shreg;
              state <= ST_SACK;
              sda_oe <= 1'b1;
            end
          end
          ST_SACK:
          begin
            bitcnt <= 4'h0;
            state <= ST_WR;
            sda_oe <= 1'b0;
          end
          ST_WR:
          begin
            if (byte_done)
            begin
              wr_en <= 1'b1;
              state <= ST_WACK;
              sda_oe <= 1'b1;
            end
          end
          ST_WACK:
          begin
            bitcnt <= 4'h0;
            subaddr <= subaddr + 8'h01;
            state <= ST_WR;
            sda_oe <= 1'b0;
          end
          ST_RD:
          begin
            if (byte_done)
            begin
              state <= ST_RACK;
              subaddr <= subaddr + 8'h01;
              sda_oe <= 1'b0;
            end
            else
            begin
              txreg <= {txreg[6:0], 1'b0};
              sda_oe <= ~txreg[6];
            end
          end
          ST_RACK:
          begin
            bitcnt <= 4'h0;
            // Master not-acknowledge ends the read burst
            if (shreg[0])
            begin
              state <= ST_IDLE;
              sda_oe <= 1'b0;
            end
            else
            begin
              state <= ST_RD;
              txreg <= rdata;
              sda_oe <= ~rdata[7];
            end
          end
          default:
          begin
            state <= ST_IDLE;
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register bank
  doac_reg #(
    .OFFSET(`DOAC_OFS_OUTPUT_PIN_CONTROL),
    .RESET(`DOAC_RST_OUTPUT_PIN_CONTROL),
    .MASK(`DOAC_MSK_OUTPUT_PIN_CONTROL)
  ) u_output_pin_control (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .wr_en(wr_en),
    .wr_addr(subaddr),
    .wr_data(shreg),
    .q(output_pin_control)
  );

  doac_reg #(
    .OFFSET(`DOAC_OFS_STANDARD_AUTOSWITCH_MASK),
    .RESET(`DOAC_RST_STANDARD_AUTOSWITCH_MASK),
    .MASK(`DOAC_MSK_STANDARD_AUTOSWITCH_MASK)
  ) u_standard_autoswitch_mask (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .wr_en(wr_en),
    .wr_addr(subaddr),
    .wr_data(shreg),
    .q(standard_autoswitch_mask)
  );

  doac_reg #(
    .OFFSET(`DOAC_OFS_CHROMA_KILL_THRESHOLD),
    .RESET(`DOAC_RST_CHROMA_KILL_THRESHOLD),
    .MASK(`DOAC_MSK_CHROMA_KILL_THRESHOLD)
  ) u_chroma_kill_threshold (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .wr_en(wr_en),
    .wr_addr(subaddr),
    .wr_data(shreg),
    .q(chroma_kill_reg)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Field decode
  wire vblank_select = output_pin_control[`DOAC_BIT_VBLANK_SELECT];
  wire general_purpose_out_level = output_pin_control[`DOAC_BIT_GP_LEVEL];
  wire shared_pin_enable = output_pin_control[`DOAC_BIT_SHARED_PIN_ENABLE];
  wire lock_indicator_select = output_pin_control[`DOAC_BIT_LOCK_INDICATOR_SELECT];
  wire decoder_pixel_out_enable = output_pin_control[`DOAC_BIT_PIXEL_OUT_ENABLE];
  wire sync_out_enable = output_pin_control[`DOAC_BIT_SYNC_OUT_ENABLE];
  wire [1:0] kill_mode = chroma_kill_reg[`DOAC_KILL_MODE_HI:`DOAC_KILL_MODE_LO];

  assign vertical_blank_enable = output_pin_control[`DOAC_BIT_VBLANK_ON]; // (RULE10)
  assign secam_autoswitch_mask = standard_autoswitch_mask[`DOAC_BIT_SECAM_MASK]; // (RULE13)
  assign ntsc443_autoswitch_mask = standard_autoswitch_mask[`DOAC_BIT_NTSC443_MASK]; // (RULE13)
  assign paln_autoswitch_mask = standard_autoswitch_mask[`DOAC_BIT_PALN_MASK]; // (RULE13)
  assign palm_autoswitch_mask = standard_autoswitch_mask[`DOAC_BIT_PALM_MASK]; // (RULE13)
  // Reserved code 01 is treated as automatic
  assign chroma_kill_force = (kill_mode == `DOAC_KILL_FORCE); // (RULE14)
  assign chroma_kill_disable = (kill_mode == `DOAC_KILL_OFF); // (RULE14)
  assign chroma_kill_auto = ~chroma_kill_force & ~chroma_kill_disable; // (RULE14)
  assign chroma_kill_threshold =
    chroma_kill_reg[`DOAC_KILL_THRESH_HI:`DOAC_KILL_THRESH_LO]; // (RULE15)

  //////////////////////////////////////////////////////////////////////////////
  // Pin selection
  wire vblank_gated = vertical_blank_signal & vertical_blank_enable; // (RULE10)
  wire shared_level = shared_pin_mux_enable ?
    (vblank_select ? vblank_gated : general_purpose_out_level) : // (RULE1) (RULE2)
    interrupt_request;
  wire vsync_level_sel = pal_field_pins_selected ?
    (lock_indicator_select ? horizontal_lock_indicator : pal_indicator) : // (RULE4)
    vsync_level;
  wire field_level_sel = genlock_selected ? genlock_output :
    (pal_field_pins_selected && lock_indicator_select) ? vertical_lock_indicator : // (RULE4)
    field_identifier;
  // Both enables required; data processor enable resets high outside this block
  wire pixel_bus_enable =
    decoder_pixel_out_enable & data_processor_out_enable; // (RULE5) (RULE6) (RULE7)
  wire field_enable = sync_out_enable | genlock_selected; // (RULE8) (RULE9)

  //////////////////////////////////////////////////////////////////////////////
  // Registered pin drivers
  doac_pin_stage #(.W(8), .OE_RESET(1'b0)) u_pixel_bus (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .level(pixel_data),
    .enable(pixel_bus_enable),
    .pin(pixel_output_bus),
    .pin_oe(pixel_output_bus_oe)
  );

  doac_pin_stage #(.W(1), .OE_RESET(1'b0)) u_hsync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .level(hsync_level),
    .enable(sync_out_enable), // (RULE8)
    .pin(hsync_pin),
    .pin_oe(hsync_pin_oe)
  );

  doac_pin_stage #(.W(1), .OE_RESET(1'b0)) u_vsync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .level(vsync_level_sel),
    .enable(sync_out_enable), // (RULE8)
    .pin(vertical_sync_or_pal_indicator_pin),
    .pin_oe(vertical_sync_or_pal_indicator_pin_oe)
  );

  doac_pin_stage #(.W(1), .OE_RESET(1'b0)) u_active_video (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .level(active_video_flag),
    .enable(sync_out_enable), // (RULE8)
    .pin(active_video_pin),
    .pin_oe(active_video_pin_oe)
  );

  doac_pin_stage #(.W(1), .OE_RESET(1'b0)) u_field (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .level(field_level_sel),
    .enable(field_enable),
    .pin(field_or_genlock_pin),
    .pin_oe(field_or_genlock_pin_oe)
  );

  doac_pin_stage #(.W(1), .OE_RESET(1'b0)) u_shared_pin (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .level(shared_level),
    .enable(shared_pin_enable), // (RULE3)
    .pin(interrupt_request_pin),
    .pin_oe(interrupt_request_pin_oe)
  );

  // Reset default keeps the pixel clock driven
  doac_pin_stage #(.W(1), .OE_RESET(1'b1)) u_pixel_clock (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .level(1'b0),
    .enable(output_pin_control[`DOAC_BIT_PIXEL_CLOCK_ENABLE]), // (RULE11)
    .pin(),
    .pin_oe(pixel_clock_pin_oe)
  );

endmodule

//--- core/doac_regs.vh
`ifndef DOAC_REGS_VH
`define DOAC_REGS_VH

// Register offsets
`define DOAC_OFS_OUTPUT_PIN_CONTROL 8'h03
`define DOAC_OFS_STANDARD_AUTOSWITCH_MASK 8'h04
`define DOAC_OFS_CHROMA_KILL_THRESHOLD 8'h06

// Reset values
`define DOAC_RST_OUTPUT_PIN_CONTROL 8'h01
`define DOAC_RST_STANDARD_AUTOSWITCH_MASK 8'hDC
`define DOAC_RST_CHROMA_KILL_THRESHOLD 8'h10

// Writable bit masks, writes clear reserved bits (autoswitch mask resets bits 7:6 to one)
`define DOAC_MSK_OUTPUT_PIN_CONTROL 8'hFF
`define DOAC_MSK_STANDARD_AUTOSWITCH_MASK 8'h3C
`define DOAC_MSK_CHROMA_KILL_THRESHOLD 8'h7F

// Output pin control fields
`define DOAC_BIT_VBLANK_SELECT 7
`define DOAC_BIT_GP_LEVEL 6
`define DOAC_BIT_SHARED_PIN_ENABLE 5
`define DOAC_BIT_LOCK_INDICATOR_SELECT 4
`define DOAC_BIT_PIXEL_OUT_ENABLE 3
`define DOAC_BIT_SYNC_OUT_ENABLE 2
`define DOAC_BIT_VBLANK_ON 1
`define DOAC_BIT_PIXEL_CLOCK_ENABLE 0

// Autoswitch mask fields
`define DOAC_BIT_SECAM_MASK 5
`define DOAC_BIT_NTSC443_MASK 4
`define DOAC_BIT_PALN_MASK 3
`define DOAC_BIT_PALM_MASK 2

// Chroma killer fields
`define DOAC_KILL_MODE_HI 6
`define DOAC_KILL_MODE_LO 5
`define DOAC_KILL_THRESH_HI 4
`define DOAC_KILL_THRESH_LO 0
`define DOAC_KILL_AUTO 2'h0
`define DOAC_KILL_FORCE 2'h2
`define DOAC_KILL_OFF 2'h3

// Serial slave address, arbitrary value
`define DOAC_SLAVE_ADDR 7'h5D

`endif

//--- core/doac_reg.v
`timescale 1ns/1ps
module doac_reg #(
  parameter [7:0] OFFSET = 8'h00,
  parameter [7:0] RESET = 8'h00,
  parameter [7:0] MASK = 8'hFF
) (
  input wire ref_clk,
  input wire rst_n,
  input wire wr_en,
  input wire [7:0] wr_addr,
  input wire [7:0] wr_data,
  output reg [7:0] q
);

  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      q <= RESET; // (RULE16)
    else if (wr_en && (wr_addr == OFFSET))
      q <= wr_data & MASK; // (RULE16)
  end

endmodule

//--- core/doac_pin_stage.v
`timescale 1ns/1ps
module doac_pin_stage #(
  parameter W = 1,
  parameter OE_RESET = 1'b0
) (
  input wire ref_clk,
  input wire rst_n,
  input wire [W-1:0] level,
  input wire enable,
  output reg [W-1:0] pin,
  output reg pin_oe
);

  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin <= {W{1'b0}};
      pin_oe <= OE_RESET;
    end
    else
    begin
      pin <= level;
      pin_oe <= enable;
    end
  end

endmodule

//--- test/doac_host_model.sv
`timescale 1ns/1ps
`include "doac_regs.vh"
module doac_host_model (
  input wire ref_clk,
  input wire sda_line,
  output reg scl,
  output reg sda_low
);
  initial
  begin
    scl = 1'h1;
    sda_low = 1'h0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Eight clocks a phase, twice the slave's sampling floor
  task automatic ph;
    repeat (8) @(posedge ref_clk);
  endtask
  task automatic start;
    @(posedge ref_clk);
    sda_low <= 1'h0;
    ph();
    scl <= 1'h1;
    ph();
    sda_low <= 1'h1;
    ph();
    scl <= 1'h0;
    ph();
  endtask
  task automatic stop;
    sda_low <= 1'h1;
    ph();
    scl <= 1'h1;
    ph();
    sda_low <= 1'h0;
    ph();
  endtask
  // Line is released, pull-up gives 1 unless the slave pulls
  task automatic bit_io(input logic d, output logic r);
    sda_low <= ~d;
    ph();
    scl <= 1'h1;
    ph();
    r = sda_line;
    scl <= 1'h0;
    ph();
  endtask
  // Ninth bit always released: slave ACK on writes, host NACK on reads
  task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(d[i], r);
      q[i] = r;
    end
    bit_io(1'h1, r);
    ack = ~r;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic k0, k1, k2;
    start();
    xfer({`DOAC_SLAVE_ADDR, 1'h0}, q, k0);
    xfer(a, q, k1);
    xfer(d, q, k2);
    stop();
    ok = k0 & k1 & k2;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic k0, k1, k2, k3;
    start();
    xfer({`DOAC_SLAVE_ADDR, 1'h0}, q, k0);
    xfer(a, q, k1);
    start();
    xfer({`DOAC_SLAVE_ADDR, 1'h1}, q, k2);
    xfer(8'hFF, d, k3);
    stop();
    ok = k0 & k1 & k2;
  endtask
endmodule

//--- test/doac_top_assertions.sv
`timescale 1ns/1ps
module doac_checker (
  input wire ref_clk,
  input wire rst_n,
  input wire scl_in,
  input wire data_processor_out_enable,
  input wire [7:0] pixel_data,
  input wire [7:0] pixel_output_bus,
  input wire pixel_output_bus_oe,
  input wire hsync_pin_oe,
  input wire vertical_sync_or_pal_indicator_pin_oe,
  input wire active_video_pin_oe,
  input wire field_or_genlock_pin,
  input wire field_or_genlock_pin_oe,
  input wire genlock_selected,
  input wire genlock_output,
  input wire shared_pin_mux_enable,
  input wire interrupt_request,
  input wire interrupt_request_pin,
  input wire pixel_clock_pin_oe,
  input wire secam_autoswitch_mask,
  input wire chroma_kill_auto,
  input wire chroma_kill_force,
  input wire chroma_kill_disable,
  input wire [4:0] chroma_kill_threshold
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////
  // Eight clocks of serial clock high leave no room for a write
  sequence s_bus_quiet;
    scl_in [*8];
  endsequence
  property p_cfg_hold;
    s_bus_quiet |-> $stable({secam_autoswitch_mask, chroma_kill_threshold});
  endproperty
  a_cfg_hold: assert property (p_cfg_hold)
    else $error("config changed while serial bus idle");
  property p_pix_gate;
    pixel_output_bus_oe |-> $past(data_processor_out_enable);
  endproperty
  a_pix_gate: assert property (p_pix_gate)
    else $error("pixel bus driven without data processor enable");
  property p_pix_data;
    $past(rst_n) && pixel_output_bus_oe |-> pixel_output_bus == $past(pixel_data);
  endproperty
  a_pix_data: assert property (p_pix_data)
    else $error("pixel bus value wrong");
  property p_genlock;
    $past(rst_n) && $past(genlock_selected) |->
      field_or_genlock_pin_oe && field_or_genlock_pin == $past(genlock_output);
  endproperty
  a_genlock: assert property (p_genlock)
    else $error("genlock pin not driven");
  property p_irq_pass;
    $past(rst_n) && $past(!shared_pin_mux_enable) |->
      interrupt_request_pin == $past(interrupt_request);
  endproperty
  a_irq_pass: assert property (p_irq_pass)
    else $error("shared pin not carrying interrupt");
  property p_reset_state;
    $rose(rst_n) |-> !pixel_output_bus_oe && pixel_clock_pin_oe && !hsync_pin_oe;
  endproperty
  a_reset_state: assert property (p_reset_state)
    else $error("output enables wrong after reset");
  property p_sync_group;
    hsync_pin_oe == vertical_sync_or_pal_indicator_pin_oe &&
      hsync_pin_oe == active_video_pin_oe && (!hsync_pin_oe || field_or_genlock_pin_oe);
  endproperty
  a_sync_group: assert property (p_sync_group)
    else $error("sync pin enables disagree");
  property p_kill_onehot;
    $onehot({chroma_kill_auto, chroma_kill_force, chroma_kill_disable});
  endproperty
  a_kill_onehot: assert property (p_kill_onehot)
    else $error("kill mode decode not one-hot");
endmodule
bind doac_top doac_checker chk (.*);

//--- test/tb.sv
`timescale 1ns/1ps
module tb;
  reg ref_clk = 1'h0;
  reg rst_n = 1'h0;
  reg shared_pin_mux_enable = 1'h0;
  reg pal_field_pins_selected = 1'h0;
  reg genlock_selected = 1'h0;
  reg data_processor_out_enable = 1'h1;
  reg [7:0] pixel_data = 8'hA5;
  reg hsync_level = 1'h1, vsync_level = 1'h0, pal_indicator = 1'h0;
  reg active_video_flag = 1'h1, field_identifier = 1'h0, genlock_output = 1'h1;
  reg horizontal_lock_indicator = 1'h0, vertical_lock_indicator = 1'h0;
  reg vertical_blank_signal = 1'h0, interrupt_request = 1'h0;
  wire scl_in, sda_low, sda_oe;
  wire sda_in = ~(sda_low | sda_oe);
  wire [7:0] pixel_output_bus;
  wire [4:0] chroma_kill_threshold;
  wire pixel_output_bus_oe, hsync_pin_oe, vertical_sync_or_pal_indicator_pin;
  wire vertical_sync_or_pal_indicator_pin_oe, active_video_pin_oe, field_or_genlock_pin;
  wire field_or_genlock_pin_oe, interrupt_request_pin, interrupt_request_pin_oe;
  wire pixel_clock_pin_oe, vertical_blank_enable, secam_autoswitch_mask;
  wire ntsc443_autoswitch_mask, paln_autoswitch_mask, palm_autoswitch_mask;
  wire chroma_kill_auto, chroma_kill_force, chroma_kill_disable;
  wire hsync_pin, active_video_pin;
  int failures = 0;
  int total_checks = 0;
  doac_top dut (.*, .sda_out());
  doac_host_model host (.ref_clk, .sda_line(sda_in), .scl(scl_in), .sda_low);
  always #4 ref_clk = ~ref_clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk8({7'h0, got}, {7'h0, exp});
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ok;
    host.wr(a, d, ok);
    chk1(ok, 1'h1);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    logic ok;
    host.rd(a, q, ok);
    chk1(ok, 1'h1);
    chk8(q, e);
  endtask
  // Step off the edge so registered pins have landed
  task automatic settle;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'h1;
    repeat (2) @(posedge ref_clk);
    rchk(8'h03, 8'h01);
    rchk(8'h04, 8'hDC);
    rchk(8'h06, 8'h10);
    settle;
    chk1(pixel_output_bus_oe | hsync_pin_oe, 1'h0);
    chk1(interrupt_request_pin_oe, 1'h0);
    chk8({secam_autoswitch_mask, ntsc443_autoswitch_mask, paln_autoswitch_mask,
          palm_autoswitch_mask, chroma_kill_threshold[4:1]}, 8'h78);
    chk1(chroma_kill_auto, 1'h1);
    $display("test defaults done");
    wr(8'h04, 8'hFF);
    rchk(8'h04, 8'h3C);
    for (int m = 0; m < 4; m++)
    begin
      wr(8'h06, {1'h1, m[1:0], m[0] ? 5'h1F : 5'h00});
      rchk(8'h06, {1'h0, m[1:0], m[0] ? 5'h1F : 5'h00});
      settle;
      chk8({5'h0, chroma_kill_auto, chroma_kill_force, chroma_kill_disable},
           m == 2 ? 8'h02 : m == 3 ? 8'h01 : 8'h04);
    end
    wr(8'h05, 8'hAA);
    rchk(8'h05, 8'h00);
    $display("test fields done");
    wr(8'h03, 8'h0D);
    settle;
    chk8(pixel_output_bus, 8'hA5);
    chk1(pixel_output_bus_oe & hsync_pin_oe & pixel_clock_pin_oe, 1'h1);
    chk8({6'h0, hsync_pin, active_video_pin}, 8'h03);
    @(posedge ref_clk);
    data_processor_out_enable <= 1'h0;
    settle;
    chk1(pixel_output_bus_oe, 1'h0);
    @(posedge ref_clk);
    data_processor_out_enable <= 1'h1;
    wr(8'h03, 8'h02);
    settle;
    chk8({5'h0, vertical_blank_enable, pixel_clock_pin_oe, pixel_output_bus_oe},
         8'h04);
    @(posedge ref_clk);
    genlock_selected <= 1'h1;
    settle;
    chk1(field_or_genlock_pin_oe, 1'h1);
    @(posedge ref_clk);
    genlock_selected <= 1'h0;
    $display("test output enables done");
    shared_pin_mux_enable <= 1'h1;
    wr(8'h03, 8'h61);
    settle;
    chk8({6'h0, interrupt_request_pin, interrupt_request_pin_oe}, 8'h03);
    wr(8'h03, 8'hA3);
    for (int v = 0; v < 2; v++)
    begin
      @(posedge ref_clk);
      vertical_blank_signal <= v[0];
      settle;
      chk1(interrupt_request_pin, v[0]);
    end
    wr(8'h03, 8'hA1);
    settle;
    chk1(interrupt_request_pin, 1'h0);
    @(posedge ref_clk);
    shared_pin_mux_enable <= 1'h0;
    interrupt_request <= 1'h1;
    settle;
    chk1(interrupt_request_pin, 1'h1);
    $display("test shared pin done");
    @(posedge ref_clk);
    pal_field_pins_selected <= 1'h1;
    pal_indicator <= 1'h1;
    vertical_lock_indicator <= 1'h1;
    wr(8'h03, 8'h05);
    settle;
    chk8({6'h0, vertical_sync_or_pal_indicator_pin, field_or_genlock_pin}, 8'h02);
    wr(8'h03, 8'h15);
    settle;
    chk8({6'h0, vertical_sync_or_pal_indicator_pin, field_or_genlock_pin}, 8'h01);
    $display("test lock select done");
    end_sim;
  end
  initial
  begin
    repeat (80000) @(posedge ref_clk);
    failures++;
    end_sim;
  end
endmodule
